// >>> src/rtcrs_timer_bank.sv
// Six reload down-counters with count readback, reload and source select.
//
// Summary of operation
// - Count reads never disturb the counter.
// - Low byte read latches high byte.
// - High register holds count bits 15 to 8.
// - Read gives count, write gives reload.
// - Reload value built from two bytes.
// - Continuous mode reloads at end of count.
// - Restart bit loads reload next clock edge.
// - Shared select register picks timers 0-3 source.
// - Pin event decrements on fifth edge.
// - Prescaler ignored for pin and clock sources.
// - Codes: 00 prescaler, 01 clock, 1x pin.
// - Timer 3 pin events from pin 1.
// - Timer 2 pin events from pin 0.
// - Timer 1 pin events from pin 1.
// - Timer 0 pin events from pin 0.
// - Prescaler divides by 4, 16, 64, 256.
// - End of count sets flag; single-pass stops.
// - Restart loads reload into counter.
`include "rtcrs_defines.svh"

module rtcrs_timer_bank (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic port_b_pin0,
    input wire logic port_b_pin1,
    input wire logic rtc_source,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr
);
    import rtcrs_pkg::*;

    localparam logic [5:0][7:0] CONTROL_IDX = {
        `RTCRS_TIMER5_CONTROL_IDX, `RTCRS_TIMER4_CONTROL_IDX,
        `RTCRS_TIMER3_CONTROL_IDX, `RTCRS_TIMER2_CONTROL_IDX,
        `RTCRS_TIMER1_CONTROL_IDX, `RTCRS_TIMER0_CONTROL_IDX};
    localparam logic [5:0][7:0] LOW_IDX = {
        `RTCRS_TIMER5_LOW_IDX, `RTCRS_TIMER4_LOW_IDX,
        `RTCRS_TIMER3_LOW_IDX, `RTCRS_TIMER2_LOW_IDX,
        `RTCRS_TIMER1_LOW_IDX, `RTCRS_TIMER0_LOW_IDX};
    localparam logic [5:0][7:0] HIGH_IDX = {
        `RTCRS_TIMER5_HIGH_IDX, `RTCRS_TIMER4_HIGH_IDX,
        `RTCRS_TIMER3_HIGH_IDX, `RTCRS_TIMER2_HIGH_IDX,
        `RTCRS_TIMER1_HIGH_IDX, `RTCRS_TIMER0_HIGH_IDX};

    rtcrs_state_type state_reg;
    rtcrs_state_type state_next;

    logic [5:0] tick;
    logic [1:0] pin_tick;
    logic rtc_tick;
    logic setup_phase;
    logic done_phase;
    logic addr_ok;
    logic [7:0] reg_idx;

    // Selects the prescaler tap for a divider code.
    function automatic logic prescale_hit(
        input logic [1:0] div,
        input logic [7:0] pre
    );
        logic hit;
        hit = 1'b0;
        case (div)
            2'b00: hit = &pre[1:0];
            2'b01: hit = &pre[3:0];
            2'b10: hit = &pre[5:0];
            2'b11: hit = &pre[7:0];
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : prescale_hit

    // Packs a timer's control fields into its register byte.
    function automatic logic [7:0] control_byte(
        input rtcrs_state_type st,
        input int unsigned n
    );
        logic [7:0] b;
        b = `RTCRS_RESET_BYTE;
        b[`RTCRS_CTL_FLAG_BIT] = st.flag[n];
        b[`RTCRS_CTL_IRQ_EN_BIT] = st.irq_en[n];
        b[`RTCRS_CTL_REPEAT_BIT] = st.repeat_sel[n];
        b[`RTCRS_CTL_DIV_LSB+:2] = st.divider[n];
        b[`RTCRS_CTL_RESTART_BIT] = st.restart_en[n];
        b[`RTCRS_CTL_ENABLE_BIT] = st.enable[n];
        return b;
    endfunction : control_byte

    // A pin event is seen after four edges, so the counter moves on the
    // fifth edge after the pin rose.
    assign pin_tick[0] = state_reg.pin_pipe[0][3] &
        ~state_reg.pin_pipe[0][4];
    assign pin_tick[1] = state_reg.pin_pipe[1][3] &
        ~state_reg.pin_pipe[1][4];
    assign rtc_tick = rtc_source & ~state_reg.rtc_prev;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_tick
            if (gi < 4) begin : g_select
                // Timers 0 and 2 watch pin 0, timers 1 and 3 pin 1.
                localparam int PIN = gi % 2;
                always_comb begin
                    case (rtcrs_src_type'(
                        state_reg.source_select[2*gi+:2]))
                        RTCRS_SRC_SYSCLK: tick[gi] = prescale_hit(
                            state_reg.divider[gi],
                            state_reg.prescale);
                        RTCRS_SRC_RTC: tick[gi] = rtc_tick;
                        RTCRS_SRC_PIN: tick[gi] =
                            pin_tick[PIN];
                        RTCRS_SRC_PIN_ALT: tick[gi] =
                            pin_tick[PIN];
                        default: tick[gi] = 1'b0;
                    endcase
                end
            end else begin : g_fixed
                always_comb begin
                    tick[gi] = prescale_hit(state_reg.divider[gi],
                        state_reg.prescale);
                end
            end
        end
    endgenerate

    assign setup_phase = psel & ~penable;
    assign done_phase = psel & penable & state_reg.ready;
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign reg_idx = paddr[9:2];

    always_comb begin
        logic [5:0] flag_set;
        logic [5:0] flag_clr;
        logic [7:0] cb;
        flag_set = 6'h00;
        flag_clr = 6'h00;
        cb = `RTCRS_RESET_BYTE;
        state_next = state_reg;
        state_next.prescale = state_reg.prescale + 8'h01;
        state_next.pin_pipe[0] = {state_reg.pin_pipe[0][3:0], port_b_pin0};
        state_next.pin_pipe[1] = {state_reg.pin_pipe[1][3:0], port_b_pin1};
        state_next.rtc_prev = rtc_source;

        // Counting runs independently of any bus access.
        for (int i = 0; i < 6; i++) begin
            if (state_reg.enable[i] && tick[i]) begin
                if (state_reg.count[i] == `RTCRS_END_COUNT) begin
                    flag_set[i] = 1'b1;
                    if (state_reg.repeat_sel[i]) begin
                        state_next.count[i] =
                            state_reg.reload[i];
                    end else begin
                        state_next.count[i] = `RTCRS_RESET_WORD;
                        state_next.enable[i] = 1'b0;
                    end
                end else begin
                    state_next.count[i] =
                        state_reg.count[i] - 16'h0001;
                end
            end
        end

        // Setup cycle: decode and capture the read answer.
        if (setup_phase) begin
            state_next.ready = 1'b1;
            state_next.err = 1'b1;
            state_next.rdata = 32'h0000_0000;
            if (addr_ok) begin
                for (int i = 0; i < 6; i++) begin
                    if (reg_idx == CONTROL_IDX[i]) begin
                        state_next.err = 1'b0;
                        if (!pwrite) begin
                            cb = control_byte(state_reg, i);
                            state_next.rdata = {24'h000000, cb};
                        end
                    end
                    if (reg_idx == LOW_IDX[i]) begin
                        state_next.err = 1'b0;
                        if (!pwrite) begin
                            state_next.rdata = {24'h000000,
                                state_reg.count[i][7:0]};
                            state_next.snap_high =
                                state_reg.count[i][15:8];
                        end
                    end
                    if (reg_idx == HIGH_IDX[i]) begin
                        state_next.err = 1'b0;
                        if (!pwrite) begin
                            state_next.rdata = {24'h000000,
                                state_reg.held_high[i]};
                        end
                    end
                end
                if (reg_idx == `RTCRS_SOURCE_SELECT_IDX) begin
                    state_next.err = 1'b0;
                    if (!pwrite) begin
                        state_next.rdata = {24'h000000,
                            state_reg.source_select};
                    end
                end
            end
        end

        // Access completion: writes and read side effects take effect.
        if (done_phase) begin
            state_next.ready = 1'b0;
            state_next.err = 1'b0;
            state_next.rdata = 32'h0000_0000;
            if (addr_ok && !state_reg.err) begin
                for (int i = 0; i < 6; i++) begin
                    if (reg_idx == CONTROL_IDX[i]) begin
                        if (pwrite) begin
                            state_next.enable[i] =
                                pwdata[`RTCRS_CTL_ENABLE_BIT];
                            state_next.irq_en[i] =
                                pwdata[`RTCRS_CTL_IRQ_EN_BIT];
                            state_next.repeat_sel[i] =
                                pwdata[`RTCRS_CTL_REPEAT_BIT];
                            state_next.divider[i] =
                                pwdata[`RTCRS_CTL_DIV_LSB+:2];
                            state_next.restart_en[i] =
                                pwdata[`RTCRS_CTL_RESTART_BIT];
                            if (pwdata[`RTCRS_CTL_RESTART_BIT]) begin
                                state_next.count[i] = state_reg.reload[i];
                            end
                        end else begin
                            // Only a flag that was actually returned is
                            // cleared, so an event after setup is kept.
                            flag_clr[i] =
                                state_reg.rdata[`RTCRS_CTL_FLAG_BIT];
                        end
                    end
                    if (reg_idx == LOW_IDX[i]) begin
                        if (pwrite) begin
                            state_next.reload[i][7:0] =
                                pwdata[7:0];
                        end else begin
                            state_next.held_high[i] =
                                state_reg.snap_high;
                        end
                    end
                    if (reg_idx == HIGH_IDX[i] && pwrite) begin
                        state_next.reload[i][15:8] =
                            pwdata[7:0];
                    end
                end
                if (reg_idx == `RTCRS_SOURCE_SELECT_IDX && pwrite) begin
                    state_next.source_select = pwdata[7:0];
                end
            end
        end

        // A set in the same cycle as a clear wins.
        state_next.flag = (state_reg.flag & ~flag_clr) | flag_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pready = state_reg.ready;
    assign prdata = state_reg.rdata;
    assign pslverr = state_reg.err;

endmodule : rtcrs_timer_bank

// >>> include/rtcrs_defines.svh
// Register indices, field positions, reset values and timing counts.
`ifndef RTCRS_DEFINES_SVH
`define RTCRS_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define RTCRS_TIMER0_CONTROL_IDX 8'h80
`define RTCRS_TIMER0_LOW_IDX 8'h81
`define RTCRS_TIMER0_HIGH_IDX 8'h82
`define RTCRS_TIMER1_CONTROL_IDX 8'h83
`define RTCRS_TIMER1_LOW_IDX 8'h84
`define RTCRS_TIMER1_HIGH_IDX 8'h85
`define RTCRS_TIMER2_CONTROL_IDX 8'h86
`define RTCRS_TIMER2_LOW_IDX 8'h87
`define RTCRS_TIMER2_HIGH_IDX 8'h88
`define RTCRS_TIMER3_CONTROL_IDX 8'h89
`define RTCRS_TIMER3_LOW_IDX 8'h8A
`define RTCRS_TIMER3_HIGH_IDX 8'h8B
`define RTCRS_TIMER4_CONTROL_IDX 8'h8C
`define RTCRS_TIMER4_LOW_IDX 8'h8D
`define RTCRS_TIMER4_HIGH_IDX 8'h8E
`define RTCRS_TIMER5_CONTROL_IDX 8'h8F
`define RTCRS_TIMER5_LOW_IDX 8'h90
`define RTCRS_TIMER5_HIGH_IDX 8'h91
`define RTCRS_SOURCE_SELECT_IDX 8'h92

// Timer control field positions.
`define RTCRS_CTL_FLAG_BIT 7
`define RTCRS_CTL_IRQ_EN_BIT 6
`define RTCRS_CTL_REPEAT_BIT 4
`define RTCRS_CTL_DIV_LSB 2
`define RTCRS_CTL_RESTART_BIT 1
`define RTCRS_CTL_ENABLE_BIT 0

// Reset values.
`define RTCRS_RESET_BYTE 8'h00
`define RTCRS_RESET_WORD 16'h0000

// End-of-count value and pin event pipeline depth.
`define RTCRS_END_COUNT 16'h0001
`define RTCRS_PIN_DELAY 5

`endif

// >>> include/rtcrs_pkg.sv
// Types shared by the reload timer bank.
package rtcrs_pkg;

    typedef enum logic [1:0] {
        RTCRS_SRC_SYSCLK = 2'b00,
        RTCRS_SRC_RTC = 2'b01,
        RTCRS_SRC_PIN = 2'b10,
        RTCRS_SRC_PIN_ALT = 2'b11
    } rtcrs_src_type;

    typedef struct packed {
        logic [5:0][15:0] count;
        logic [5:0][15:0] reload;
        logic [5:0][7:0] held_high;
        logic [5:0] enable;
        logic [5:0] irq_en;
        logic [5:0] repeat_sel;
        logic [5:0] restart_en;
        logic [5:0] flag;
        logic [5:0][1:0] divider;
        logic [7:0] source_select;
        logic [7:0] prescale;
        logic [1:0][4:0] pin_pipe;
        logic rtc_prev;
        logic [7:0] snap_high;
        logic ready;
        logic err;
        logic [31:0] rdata;
    } rtcrs_state_type;

endpackage : rtcrs_pkg

// >>> sim/rtcrs_event_source.sv
// Event source model driving the port pins and the clock event line.
module rtcrs_event_source (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] fire,
    output logic port_b_pin0,
    output logic port_b_pin1,
    output logic rtc_source
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each request gives a one-cycle pulse; callers space pulses by three
    // or more cycles so the event rate stays below half the clock.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {rtc_source, port_b_pin1, port_b_pin0} <= 3'h0;
        end else begin
            {rtc_source, port_b_pin1, port_b_pin0} <= fire;
        end
    end
endmodule : rtcrs_event_source

// >>> sim/rtcrs_timer_bank_assertions.sv
// Bus-level checks for the reload timer bank.
module rtcrs_timer_bank_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (
        psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("answer held too long");
    a_ready_cause: assert property (
        pready |-> $past(psel) && !$past(penable))
        else $error("answer without setup");
    a_err_align: assert property (
        psel && !penable && paddr[1:0] != 2'h0
        |=> pslverr && prdata == 32'h0) else $error("misaligned accepted");
    a_err_range: assert property (
        psel && !penable && paddr[11:10] != 2'h0
        |=> pslverr && prdata == 32'h0) else $error("high address accepted");
    a_select_mapped: assert property (
        psel && !penable && paddr == 12'h248
        |=> pready && !pslverr) else $error("select register refused");
    a_count_mapped: assert property (
        psel && !penable && paddr == 12'h208
        |=> !pslverr) else $error("count high refused");
    a_byte_only: assert property (
        pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_idle_quiet: assert property (
        !pready |-> prdata == 32'h0 && !pslverr)
        else $error("outputs active while idle");
    c_error: cover property (pready && pslverr);
    c_read_data: cover property (pready && !pwrite && prdata != 32'h0);
    c_select_write: cover property (psel && penable && pwrite
        && paddr == 12'h248);
endmodule : rtcrs_timer_bank_assertions

bind rtcrs_timer_bank rtcrs_timer_bank_assertions u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr));

// >>> sim/reload_timer_count_reload_source_bench.sv
// Self-checking bench for the reload timer bank.
module reload_timer_count_reload_source_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, p0, p1, rtc;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [2:0] fire = 3'h0;
    logic [7:0] q;
    logic e;
    int bad_count = 0, num_checks = 0, cycles = 0;
    rtcrs_timer_bank uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .port_b_pin0(p0), .port_b_pin1(p1), .rtc_source(rtc),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    rtcrs_event_source u_src (.pclk(pclk), .presetn(presetn), .fire(fire),
        .port_b_pin0(p0), .port_b_pin1(p1), .rtc_source(rtc));
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count = bad_count + 1;
            conclude();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic wr, input logic [11:0] a,
        input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [11:0] a, input logic [7:0] m,
        input logic [7:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(q & m, exp);
    endtask : rd
    task automatic pulse(input logic [2:0] f);
        @(posedge pclk);
        fire <= f;
        @(posedge pclk);
        fire <= 3'h0;
        repeat (8) @(posedge pclk);
    endtask : pulse
    function automatic logic [11:0] ctl(input int n);
        return 12'h200 + 12'(12 * n);
    endfunction : ctl
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (int n = 0; n < 6; n++) begin
            rd(ctl(n) + 12'h8, 8'hFF, 8'h00);
            rd(ctl(n) + 12'h4, 8'hFF, 8'h00);
        end
        rd(12'h248, 8'hFF, 8'h00);
        xfer(1'b0, 12'h300, 8'h00);
        chk({7'h0, e}, 8'h01);
        xfer(1'b1, 12'h201, 8'h55);
        chk({7'h0, e}, 8'h01);
        xfer(1'b1, 12'h248, 8'hEA);
        rd(12'h248, 8'hFF, 8'hEA);
        for (int n = 0; n < 4; n++) begin
            xfer(1'b1, ctl(n) + 12'h4, 8'h10);
            xfer(1'b1, ctl(n) + 12'h8, 8'h01);
            xfer(1'b1, ctl(n), 8'h03);
        end
        rd(ctl(0) + 12'h4, 8'hFF, 8'h10);
        pulse(3'b001);
        pulse(3'b010);
        pulse(3'b010);
        rd(ctl(0) + 12'h4, 8'hFF, 8'h0F);
        rd(ctl(0) + 12'h4, 8'hFF, 8'h0F);
        rd(ctl(1) + 12'h4, 8'hFF, 8'h0E);
        rd(ctl(2) + 12'h4, 8'hFF, 8'h0F);
        rd(ctl(3) + 12'h4, 8'hFF, 8'h0E);
        rd(ctl(3) + 12'h8, 8'hFF, 8'h01);
        xfer(1'b1, 12'h248, 8'h55);
        pulse(3'b100);
        rd(ctl(0) + 12'h4, 8'hFF, 8'h0E);
        rd(ctl(3) + 12'h4, 8'hFF, 8'h0D);
        xfer(1'b1, ctl(4) + 12'h4, 8'h03);
        xfer(1'b1, ctl(4), 8'h13);
        xfer(1'b1, ctl(5) + 12'h4, 8'h02);
        xfer(1'b1, ctl(5), 8'h0B);
        repeat (400) @(posedge pclk);
        rd(ctl(4) + 12'h4, 8'hFC, 8'h00);
        chk({7'h0, q != 8'h00}, 8'h01);
        rd(ctl(4) + 12'h8, 8'hFF, 8'h00);
        rd(ctl(5), 8'h81, 8'h80);
        rd(ctl(5), 8'h80, 8'h00);
        rd(ctl(5) + 12'h4, 8'hFF, 8'h00);
        conclude();
    end
endmodule : reload_timer_count_reload_source_bench
